// File: dasp_dev.sv
`timescale 1ns/10ps
module dasp_dev
   import dasp_pkg::*;
(
   input wire logic bclk,
   input wire logic [2:0] fmt,
   input wire logic din,
   output logic dout
);
   logic sc;
   assign sc = fmt inside {FMT_DSP, FMT_MONO} ? ~bclk : bclk;
   // loopback: each bit taken in goes straight back, msb order kept
   // line never released, so the keeper has nothing to hold
   initial dout = 1'b0;
   always @(posedge sc) dout <= din;
endmodule // dasp_dev

// File: dasp_host.sv
`timescale 1ns/10ps
module dasp_host
   import dasp_pkg::*;
#(
   parameter int HALF_CYC = BCLK_HALF_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic enable,
   input wire dasp_cfg_t cfg,
   input wire dasp_pair_t tx_data,
   output logic tx_taken,
   output dasp_pair_t rx_data,
   output logic rx_valid,
   output logic bclk_o,
   output logic wclk_o,
   output logic sdata_o,
   input wire logic sdata_i
);
   typedef enum logic {ST_IDLE, ST_RUN} dasp_state_t;

   typedef struct packed {
      dasp_state_t st;
      logic [7:0] div;
      logic bclk;
      logic bclk_pin;
      logic wclk;
      logic sdata;
      logic [8:0] cnt;
      dasp_cfg_t cfg;
      dasp_pair_t tx;
      dasp_pair_t rxw;
      dasp_pair_t rx;
      logic rx_valid;
      logic taken;
      logic sync1;
      logic sync2;
   } dasp_regs_t;

   localparam dasp_regs_t REGS_RESET = '{st: ST_IDLE, div: 8'h00,
      bclk: 1'b1, bclk_pin: 1'b1, wclk: 1'b0, sdata: 1'b0, cnt: 9'h000,
      cfg: CFG_RESET, tx: '0, rxw: '0, rx: '0, rx_valid: 1'b0,
      taken: 1'b0, sync1: 1'b0, sync2: 1'b0};

   dasp_regs_t r_q;
   dasp_regs_t r_d;

   function automatic logic [5:0] width_bits(input logic [1:0] wsel);
      case (wsel)
         WSEL_16: width_bits = 6'h10;
         WSEL_20: width_bits = 6'h14;
         WSEL_24: width_bits = 6'h18;
         default: width_bits = 6'h20;
      endcase
   endfunction

   // keeps the far end inside its frame limits, whatever the user asks
   function automatic dasp_cfg_t fit_cfg(input dasp_cfg_t c);
      int w;
      int need;
      int frame;
      fit_cfg = c;
      w = int'(width_bits(c.wsel));
      // i2s data starts one bit after the frame edge and positions are
      // counted inside each half, so a half of exactly w bits would lose
      // the lsb: every format gets one spare bit clock per channel
      need = w + 1;
      if (int'(c.slots) < need) begin
         fit_cfg.slots = 8'(need);
      end
      frame = 2 * int'(fit_cfg.slots);
      if (int'(c.offset) > frame - w) begin
         fit_cfg.offset = 8'(frame - w);
      end
   endfunction

   // which channel and bit index the given bit clock of the frame holds
   function automatic dasp_slot_t slot_of(input dasp_cfg_t c,
                                          input logic [8:0] cnt);
      int w;
      int s;
      int p;
      int k;
      logic h;
      logic ok;
      w = int'(width_bits(c.wsel));
      s = int'(c.slots);
      h = (int'(cnt) >= s);
      p = h ? int'(cnt) - s : int'(cnt);
      ok = 1'b1;
      slot_of.right = h;
      case (c.fmt)
         FMT_I2S: k = p - 1 - int'(c.offset);
         FMT_LEFT: k = p - int'(c.offset);
         FMT_RIGHT: k = p - (s - w);
         FMT_DSP: begin
            k = int'(cnt) - int'(c.offset);
            slot_of.right = (k >= w);
            if (k >= w) begin
               k = k - w;
            end
         end
         FMT_MONO: begin
            k = int'(cnt) - int'(c.offset);
            slot_of.right = 1'b0;
         end
         default: begin
            k = 0;
            ok = 1'b0;
         end
      endcase
      slot_of.valid = ok && (k >= 0) && (k < w);
      slot_of.idx = slot_of.valid ? 5'(w - 1 - k) : 5'h00;
   endfunction

   function automatic logic frame_level(input dasp_cfg_t c,
                                        input logic [8:0] cnt);
      logic first_half;
      first_half = (cnt < {1'b0, c.slots});
      case (c.fmt)
         FMT_I2S: frame_level = !first_half;
         FMT_LEFT, FMT_RIGHT: frame_level = first_half;
         default: frame_level = c.wclk_square ? first_half
                                              : (cnt == 9'h000);
      endcase
   endfunction

   always_comb begin
      dasp_slot_t sl;
      logic fall;
      logic wrap;
      logic [8:0] last;
      logic inv;
      sl = '0;
      fall = 1'b0;
      wrap = 1'b0;
      last = 9'h000;
      inv = 1'b0;
      r_d = r_q;
      r_d.sync1 = sdata_i;
      r_d.sync2 = r_q.sync1;
      r_d.rx_valid = 1'b0;
      r_d.taken = 1'b0;
      case (r_q.st)
         ST_IDLE: begin
            r_d.cfg = fit_cfg(cfg);
            r_d.cnt = {r_d.cfg.slots, 1'b0} - 9'h001;
            r_d.div = 8'h00;
            r_d.bclk = 1'b1;
            r_d.wclk = 1'b0;
            r_d.sdata = 1'b0;
            if (enable) begin
               r_d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (r_q.div == 8'(HALF_CYC - 1)) begin
               r_d.div = 8'h00;
               r_d.bclk = !r_q.bclk;
               fall = r_q.bclk;
            end else begin
               r_d.div = r_q.div + 8'h01;
            end
            if (fall) begin
               // sync2 lags the pin by two cycles, still inside this bit
               sl = slot_of(r_q.cfg, r_q.cnt);
               if (sl.valid) begin
                  if (sl.right) begin
                     r_d.rxw.right[sl.idx] = r_q.sync2;
                  end else begin
                     r_d.rxw.left[sl.idx] = r_q.sync2;
                  end
               end
               last = {r_q.cfg.slots, 1'b0} - 9'h001;
               wrap = (r_q.cnt == last);
               r_d.cnt = wrap ? 9'h000 : r_q.cnt + 9'h001;
               if (wrap) begin
                  // settings only change on a frame boundary
                  r_d.rx = r_d.rxw;
                  r_d.rx_valid = 1'b1;
                  r_d.rxw = '0;
                  r_d.tx = tx_data;
                  r_d.taken = 1'b1;
                  r_d.cfg = fit_cfg(cfg);
                  if (!enable) begin
                     r_d.st = ST_IDLE;
                  end
               end
               r_d.wclk = frame_level(r_d.cfg, r_d.cnt);
               sl = slot_of(r_d.cfg, r_d.cnt);
               if (sl.valid) begin
                  r_d.sdata = sl.right ? r_d.tx.right[sl.idx]
                                       : r_d.tx.left[sl.idx];
               end else begin
                  r_d.sdata = 1'b0;
               end
            end
         end
         default: r_d = REGS_RESET;
      endcase
      // dsp and mono sample on the falling pin edge: invert the pin
      inv = (r_d.cfg.fmt == FMT_DSP) || (r_d.cfg.fmt == FMT_MONO);
      r_d.bclk_pin = r_d.bclk ^ inv;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         r_q <= REGS_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign tx_taken = r_q.taken;
   assign rx_data = r_q.rx;
   assign rx_valid = r_q.rx_valid;
   assign bclk_o = r_q.bclk_pin;
   assign wclk_o = r_q.wclk;
   assign sdata_o = r_q.sdata;
endmodule // dasp_host

// File: dasp_host_sva.sv
`timescale 1ns/10ps
module dasp_host_sva
   import dasp_pkg::*;
#(
   parameter int HALF_CYC = BCLK_HALF_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic enable,
   input wire dasp_cfg_t cfg,
   input wire dasp_pair_t tx_data,
   input wire logic tx_taken,
   input wire dasp_pair_t rx_data,
   input wire logic rx_valid,
   input wire logic bclk_o,
   input wire logic wclk_o,
   input wire logic sdata_o,
   input wire logic sdata_i
);
   localparam int BIT_CYC = 2 * HALF_CYC;
   logic prev_q, seen_q, inv, off0;
   logic [7:0] cnt_q;
   int w;
   assign w = cfg.wsel == WSEL_32 ? 32 : 16 + 4 * int'(cfg.wsel);
   assign inv = cfg.fmt == FMT_DSP || cfg.fmt == FMT_MONO;
   assign off0 = cfg.offset == 8'h00;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // first toggle after reset is skipped: idle time after reset is not a half period
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prev_q <= 1'b1;
         seen_q <= 1'b0;
         cnt_q <= 8'h00;
      end else begin
         prev_q <= bclk_o;
         seen_q <= seen_q | (bclk_o != prev_q);
         cnt_q <= (bclk_o != prev_q) ? 8'h00 : cnt_q + 8'h01;
      end
   end
   sequence i2s_fall_s;
      $fell(wclk_o) && cfg.fmt == FMT_I2S && off0;
   endsequence
   sequence quiet_s;
      !tx_taken [*8];
   endsequence
   bclk_half_a:
      assert property ($changed(bclk_o) && seen_q |-> cnt_q == HALF_CYC - 1)
      else $error("bit clock half period wrong");
   pulse_pair_a:
      assert property (tx_taken |-> rx_valid ##1 quiet_s)
      else $error("frame pulses wrong");
   data_edge_a:
      assert property ($changed(sdata_o) |-> $changed(bclk_o))
      else $error("data moved off a bit edge");
   frame_phase_a:
      assert property ($changed(wclk_o) |->
         (inv ? $rose(bclk_o) : $fell(bclk_o)))
      else $error("frame edge off phase");
   i2s_msb_a:
      assert property (i2s_fall_s |->
         !sdata_o ##BIT_CYC (sdata_o == tx_data.left[w - 1]))
      else $error("i2s msb misplaced");
   dsp_msb_a:
      assert property ($rose(wclk_o) && inv && off0 |->
         sdata_o == tx_data.left[w - 1]) else $error("dsp msb misplaced");
   left_msb_a:
      assert property ($fell(wclk_o) && cfg.fmt == FMT_LEFT && off0 |->
         sdata_o == tx_data.right[w - 1]) else $error("left msb misplaced");
   right_lsb_a:
      assert property ($fell(wclk_o) && cfg.fmt == FMT_RIGHT |->
         $past(sdata_o) == tx_data.left[0]) else $error("right lsb misplaced");
endmodule // dasp_host_sva
bind dasp_host dasp_host_sva #(.HALF_CYC(HALF_CYC)) i_dasp_host_sva (.*);

// File: dasp_pkg.sv
// Functional notes
// - samples travel msb first, width 16-32
// - clock master drives bit and frame clocks
// - frame rate equals higher sample rate
// - slot sharing with i2s, left, right, dsp
// - i2s msb on second rise after edge
// - i2s bit clocks per channel >= width
// - offset plus width within frame length
// - dsp: rise starts, left then right
// - dsp/justified frame exceeds twice width
// - right-justified lsb just before frame edge
// - left-justified msb right after frame edge
// - mono pcm: rise starts single channel
package dasp_pkg;
   localparam logic [2:0] FMT_I2S = 3'h0;
   localparam logic [2:0] FMT_DSP = 3'h1;
   localparam logic [2:0] FMT_RIGHT = 3'h2;
   localparam logic [2:0] FMT_LEFT = 3'h3;
   localparam logic [2:0] FMT_MONO = 3'h4;
   localparam logic [1:0] WSEL_16 = 2'h0;
   localparam logic [1:0] WSEL_20 = 2'h1;
   localparam logic [1:0] WSEL_24 = 2'h2;
   localparam logic [1:0] WSEL_32 = 2'h3;
   localparam logic [1:0] WSEL_RESET = WSEL_24;
   localparam logic [7:0] OFFSET_RESET = 8'h00;
   localparam logic [7:0] SLOTS_RESET = 8'h20;
   localparam int SYS_PERIOD_NS = 100;
   localparam int BCLK_PERIOD_NS = 800;
   localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);

   typedef struct packed {
      logic [2:0] fmt;
      logic [1:0] wsel;
      logic [7:0] offset;
      logic [7:0] slots;
      logic wclk_square;
   } dasp_cfg_t;

   localparam dasp_cfg_t CFG_RESET = '{fmt: FMT_I2S, wsel: WSEL_RESET,
      offset: OFFSET_RESET, slots: SLOTS_RESET, wclk_square: 1'b0};

   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } dasp_pair_t;

   typedef struct packed {
      logic valid;
      logic right;
      logic [4:0] idx;
   } dasp_slot_t;
endpackage

// File: dual_audio_serial_port_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   fails++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module dual_audio_serial_port_test;
   import dasp_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic enable = 1'b0;
   dasp_cfg_t cfg = CFG_RESET;
   dasp_pair_t tx_data = {32'hA5C396E1, 32'h5A3C1E69};
   dasp_pair_t rx_data, exp_d;
   logic tx_taken, rx_valid, bclk_o, wclk_o, sdata_o, sdata_i;
   logic [31:0] mask;
   int fails = 0;
   int check_count = 0;
   initial forever #50 clk_sys = ~clk_sys;
   dasp_host #(.HALF_CYC(4)) i_dasp_host (.clk_sys(clk_sys), .arst_n(arst_n),
      .enable(enable), .cfg(cfg), .tx_data(tx_data), .tx_taken(tx_taken),
      .rx_data(rx_data), .rx_valid(rx_valid), .bclk_o(bclk_o),
      .wclk_o(wclk_o), .sdata_o(sdata_o), .sdata_i(sdata_i));
   dasp_dev i_dasp_dev (.bclk(bclk_o), .fmt(cfg.fmt), .din(sdata_o),
      .dout(sdata_i));
   task automatic results;
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_rx;
      int n;
      @(negedge clk_sys);
      for (n = 0; n < 3000 && rx_valid !== 1'b1; n++) @(negedge clk_sys);
      if (n == 3000) begin
         fails++;
         results();
      end
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      `CHK("idle pins", 5'h10, {bclk_o, wclk_o, sdata_o, rx_valid, tx_taken})
      // a reset between setups keeps cfg still while the link runs
      // code 5 is reserved: no data bits go out, so nothing comes back
      for (int f = 0; f < 6; f++) begin
         for (int w = 0; w < 4; w++) begin
            @(posedge clk_sys);
            arst_n <= 1'b0;
            enable <= 1'b0;
            cfg <= '{f[2:0], w[1:0], {7'h00, w == 1}, 8'h20, w[0]};
            @(posedge clk_sys);
            arst_n <= 1'b1;
            enable <= 1'b1;
            wait_rx();
            wait_rx();
            mask = w == 3 ? 32'hFFFFFFFF : (32'h1 << (16 + 4 * w)) - 32'h1;
            exp_d.left = f > 4 ? 32'h0 : tx_data.left & mask;
            exp_d.right = f > 3 ? 32'h0 : tx_data.right & mask;
            `CHK("rx_data", exp_d, rx_data)
         end
      end
      results();
   end
endmodule // dual_audio_serial_port_test
